/* hw/mhu_pkg.sv */
package mhu_pkg;

	// ------------------------------------------------------------------
	// Clock and time base
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int CLK_HZ        = 200_000_000;
	localparam int MS_NS         = 1_000_000;
	localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;
	localparam int DEEP_WAKE_MS  = 345;
	localparam int BAUD_BPS      = 115_200;
	localparam int FIFO_DEPTH    = 64;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_DATA    = 8'h00;
	localparam logic [7:0] ADDR_CTRL    = 8'h04;
	localparam logic [7:0] ADDR_STATUS  = 8'h08;
	localparam logic [7:0] ADDR_IRQ_ST  = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h10;
	localparam logic [7:0] ADDR_BAUD    = 8'h14;
	localparam logic [7:0] ADDR_TIMES   = 8'h18;
	localparam logic [7:0] ADDR_EVENT   = 8'h1C;
	localparam logic [7:0] ADDR_POWER   = 8'h20;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CTRL_FLOW      = 0;
	localparam int CTRL_WAKE_RTS  = 1;
	localparam int CTRL_DEDICATED_WAKE_PIN_ZERO     = 2;
	localparam int CTRL_RING_URC  = 3;
	localparam int CTRL_RING_DATA = 4;
	localparam int CTRL_ONLINE    = 5;
	localparam int IRQ_RX         = 0;
	localparam int IRQ_TIMEOUT    = 1;
	localparam int IRQ_WAKE       = 2;
	localparam int IRQ_OVERRUN    = 3;
	localparam int EVT_URC        = 0;
	localparam int EVT_DATA       = 1;
	localparam int PWR_SLEEP      = 0;
	localparam int PWR_DEEP       = 1;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0]  CTRL_RST     = 8'h1B;
	localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_BPS);
	localparam logic [15:0] TIMEOUT_RST  = 16'h0064;
	localparam logic [15:0] RING_MS_RST  = 16'h0064;

	// ------------------------------------------------------------------
	// Power states
	// ------------------------------------------------------------------
	typedef enum logic [2:0]
	{
		MHU_ASLEEP = 3'b001,
		MHU_WAKING = 3'b010,
		MHU_ACTIVE = 3'b100
	} mhu_pwr_t;

endpackage

/* hw/mhu_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Byte queue connection between the serial logic and its FIFOs.
interface mhu_fifo_if #(parameter int W = 8);
	logic [W-1:0] wdata;
	logic         push;
	logic         full;
	logic [W-1:0] rdata;
	logic         pop;
	logic         empty;

	modport fifo (input wdata, push, pop, output full, rdata, empty);
	modport user (output wdata, push, pop, input full, rdata, empty);
endinterface

`default_nettype wire

/* hw/mhu_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Show-ahead FIFO
// ----------------------------------------------------------------------
module mhu_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = mhu_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rst_b_i,
	// Queue port
	mhu_fifo_if.fifo  q
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   count;
	wire           do_push;
	wire           do_pop;

	// Pushes into a full queue and pops from an empty one are dropped.
	assign do_push = q.push && !q.full;
	assign do_pop  = q.pop && !q.empty;
	assign q.full  = (count == (AW+1)'(DEPTH));
	assign q.empty = (count == '0);
	assign q.rdata = mem[rd_ptr];

	// Storage has no reset; only the pointers and the level need a defined value.
	always_ff @(posedge sys_clk_i)
	begin
		if (do_push)
			mem[wr_ptr] <= q.wdata;
	end

	// Pointer and level bookkeeping.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			wr_ptr <= do_push ? AW'(wr_ptr + 1'b1) : wr_ptr;
			rd_ptr <= do_pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
			count  <= (AW+1)'(count + do_push - do_pop);
		end
	end

	a_fifo_no_over : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R11
		q.full && q.push && !q.pop |=> q.full && count == (AW+1)'(DEPTH))
		else $error("FIFO level moved past its depth.");
endmodule

`default_nettype wire

/* hw/mhu_ring_pulse.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Ring alert pulse stretcher, length counted in millisecond ticks
// ----------------------------------------------------------------------
module mhu_ring_pulse (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_b_i,
	// Control
	input  wire logic        tick_i,
	input  wire logic        trigger_i,
	input  wire logic [15:0] dur_ms_i,
	// Result
	output logic             active_o
);
	logic [15:0] remain;
	wire  [15:0] load_val;

	// A zero length would wrap into a 65536-tick pulse, so it is taken as one tick.
	assign load_val = (dur_ms_i == 16'h0000) ? 16'h0001 : dur_ms_i;

	// A new trigger restarts the full length, so alerts never merge short.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			remain   <= 16'h0000;
			active_o <= 1'b0;
		end
		else if (trigger_i)
		begin
			remain   <= load_val; // see R13
			active_o <= 1'b1;
		end
		else if (tick_i && active_o)
		begin
			remain   <= remain - 16'h0001;
			active_o <= (remain != 16'h0001);
		end
	end

	a_ring_starts : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R1
		trigger_i |=> active_o && remain == $past(load_val))
		else $error("Ring pulse did not start on its trigger.");

	a_ring_held : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R13
		active_o && !tick_i && !trigger_i |=> active_o && $stable(remain))
		else $error("Ring pulse ended between ticks.");
endmodule

`default_nettype wire

/* hw/mhu_uart_link.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Ring host on pending codes or network data.
// R2: Online mode rings for codes; host returns.
// R3: Flow, no low power: host may ignore ring.
// R4: Host request line asserted wakes the modem.
// R5: Clear line moves with modem receive readiness.
// R6: No flow, no low power: host watches awake.
// R7: Awake indicator shows only awake or asleep.
// R8: No flow: host polls, waits OK first.
// R9: No flow: host pulls request low.
// R10: No flow: host stays at or below 115200.
// R11: Receive and transmit FIFOs hold 64 bytes.
// R12: Inactivity timeout programmable, default 100 ms.
// R13: Ring alert length programmable, default 100 ms.
// R14: Reset enables flow control and request wake.
// R15: Wake pin zero may replace request wake.
// R16: Awake indicator low asleep, high active.
// R17: Clear line low when ready to receive.
// R18: Deep wake: awake 345 ms before clear.
// R19: Host pauses while clear line is high.
module mhu_uart_link #(
	parameter int TICK_CYCLES = mhu_pkg::TICK_CYCLES,
	parameter int FIFO_DEPTH  = mhu_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_b_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Host link pins
	input  wire logic        host_rxd_i,
	output logic             modem_txd_o,
	input  wire logic        host_request_line_n_i,
	output logic             modem_clear_line_n_o,
	input  wire logic        dedicated_wake_pin_zero_i,
	output logic             modem_awake_indicator_o,
	output logic             ring_alert_n_o,
	// Interrupt
	output logic             irq_o
);
	localparam int TW = $clog2(TICK_CYCLES);

	// ------------------------------------------------------------------
	// Byte mask helper
	// ------------------------------------------------------------------
	function automatic logic [31:0] mhu_wmask(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[b*8 +: 8] = new_v[b*8 +: 8];
		return r;
	endfunction

	mhu_fifo_if #(.W(8)) rxq ();
	mhu_fifo_if #(.W(8)) txq ();

	logic [7:0]  ctrl;
	logic [3:0]  irq_st;
	logic [3:0]  irq_msk;
	logic [15:0] baud_div;
	logic [15:0] timeout_ms;
	logic [15:0] ring_ms;
	logic [1:0]  evt;
	logic [1:0]  pwr_cmd;
	logic        deep_flag;
	logic        active_q;
	logic        rx_meta, rx_s, rts_meta, rts_s, wk_meta, wk_s;
	logic [TW-1:0] tick_cnt;
	logic        tick;
	logic [8:0]  wake_ms;
	logic [15:0] idle_ms;
	logic        idle_armed;
	logic        rx_busy, tx_busy;
	logic [15:0] rx_cnt, tx_cnt;
	logic [3:0]  rx_bit, tx_bit;
	logic [7:0]  rx_shift;
	logic [9:0]  tx_shift;
	logic        rx_push;
	logic        ring_active;
	mhu_pkg::mhu_pwr_t state, next_state;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire         req     = wb_cyc_i && wb_stb_i;
	wire         wr_go   = req && wb_we_i && wb_ack_o;
	wire         rd_go   = req && !wb_we_i && wb_ack_o;
	wire         hit_dat = (wb_adr_i == mhu_pkg::ADDR_DATA);
	wire         hit_ctl = (wb_adr_i == mhu_pkg::ADDR_CTRL);
	wire         hit_ist = (wb_adr_i == mhu_pkg::ADDR_IRQ_ST);
	wire         hit_msk = (wb_adr_i == mhu_pkg::ADDR_IRQ_MSK);
	wire         hit_bau = (wb_adr_i == mhu_pkg::ADDR_BAUD);
	wire         hit_tim = (wb_adr_i == mhu_pkg::ADDR_TIMES);
	wire         hit_evt = (wb_adr_i == mhu_pkg::ADDR_EVENT);
	wire         hit_pwr = (wb_adr_i == mhu_pkg::ADDR_POWER);
	wire         awake   = (state != mhu_pkg::MHU_ASLEEP);
	wire         active  = (state == mhu_pkg::MHU_ACTIVE);
	wire [31:0]  status  = {24'h00_0000, deep_flag, ring_active,
		!modem_clear_line_n_o, awake, txq.full, txq.empty,
		rxq.full, rxq.empty};
	wire [31:0]  rd_mux  =
		hit_dat ? {24'h00_0000, rxq.rdata} :
		hit_ctl ? {24'h00_0000, ctrl} :
		(wb_adr_i == mhu_pkg::ADDR_STATUS) ? status :
		hit_ist ? {28'h000_0000, irq_st} :
		hit_msk ? {28'h000_0000, irq_msk} :
		hit_bau ? {16'h0000, baud_div} :
		hit_tim ? {ring_ms, timeout_ms} : 32'h0000_0000;
	wire [31:0]  wr_val  = mhu_wmask(rd_mux, wb_dat_i, wb_sel_i);
	wire [3:0]   ist_clr = (wr_go && hit_ist && wb_sel_i[0]) ?
		wb_dat_i[3:0] : 4'h0;

	// ------------------------------------------------------------------
	// Wake, ring and event decode
	// ------------------------------------------------------------------
	wire wake_req = (ctrl[mhu_pkg::CTRL_WAKE_RTS] && !rts_s) || // see R4
		(ctrl[mhu_pkg::CTRL_DEDICATED_WAKE_PIN_ZERO] && wk_s);                    // see R15
	wire ring_go  = (evt[mhu_pkg::EVT_URC] && (ctrl[mhu_pkg::CTRL_RING_URC]
		|| ctrl[mhu_pkg::CTRL_ONLINE])) ||                      // see R2
		(evt[mhu_pkg::EVT_DATA] && ctrl[mhu_pkg::CTRL_RING_DATA]); // see R1
	wire rx_mid   = rx_busy && (rx_cnt == 16'h0000);
	wire tx_start = !tx_busy && !txq.empty && active &&
		(!ctrl[mhu_pkg::CTRL_FLOW] || !rts_s);
	wire cts_rdy  = (next_state == mhu_pkg::MHU_ACTIVE) &&
		(!ctrl[mhu_pkg::CTRL_FLOW] || !rxq.full); // see R17
	wire to_hit   = idle_armed && tick && (idle_ms + 16'h0001 >= timeout_ms);
	wire [3:0] irq_set = {rx_push && rxq.full, active && !active_q,
		to_hit, rx_push};

	assign rxq.wdata = rx_shift;
	assign rxq.push  = rx_push;
	assign rxq.pop   = rd_go && hit_dat;
	assign txq.wdata = wb_dat_i[7:0];
	assign txq.push  = wr_go && hit_dat && wb_sel_i[0];
	assign txq.pop   = tx_start;

	mhu_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo // see R11
	(
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.q         (rxq)
	);

	mhu_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo // see R11
	(
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.q         (txq)
	);

	mhu_ring_pulse u_ring
	(
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.tick_i    (tick),
		.trigger_i (ring_go),
		.dur_ms_i  (ring_ms),
		.active_o  (ring_active)
	);

	// ------------------------------------------------------------------
	// Pin synchronisers and millisecond tick
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			{rx_meta, rx_s, rts_meta, rts_s, wk_meta, wk_s} <= 6'b11_1100;
			tick_cnt <= '0;
			tick     <= 1'b0;
		end
		else
		begin
			{rx_meta, rx_s} <= {host_rxd_i, rx_meta};
			{rts_meta, rts_s} <= {host_request_line_n_i, rts_meta};
			{wk_meta, wk_s} <= {dedicated_wake_pin_zero_i, wk_meta};
			tick     <= (tick_cnt == TW'(TICK_CYCLES - 1));
			tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0 :
				TW'(tick_cnt + 1'b1);
		end
	end

	// ------------------------------------------------------------------
	// Registers and bus answer
	// ------------------------------------------------------------------
	// Event and power writes are one-cycle commands, not stored settings.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wb_ack_o   <= 1'b0;
			wb_dat_o   <= 32'h0000_0000;
			ctrl       <= mhu_pkg::CTRL_RST; // see R14
			irq_msk    <= 4'h0;
			irq_st     <= 4'h0;
			baud_div   <= mhu_pkg::BAUD_DIV_RST;
			timeout_ms <= mhu_pkg::TIMEOUT_RST;
			ring_ms    <= mhu_pkg::RING_MS_RST;
			evt        <= 2'b00;
			pwr_cmd    <= 2'b00;
			irq_o      <= 1'b0;
		end
		else
		begin
			wb_ack_o <= req && !wb_ack_o;
			wb_dat_o <= rd_mux;
			ctrl     <= (wr_go && hit_ctl) ? wr_val[7:0] : ctrl; // see R15
			irq_msk  <= (wr_go && hit_msk) ? wr_val[3:0] : irq_msk;
			baud_div <= (wr_go && hit_bau) ? wr_val[15:0] : baud_div;
			timeout_ms <= (wr_go && hit_tim) ? wr_val[15:0] : timeout_ms;
			ring_ms  <= (wr_go && hit_tim) ? wr_val[31:16] : ring_ms;
			evt      <= (wr_go && hit_evt) ? wr_val[1:0] : 2'b00;
			pwr_cmd  <= (wr_go && hit_pwr) ? wr_val[1:0] : 2'b00;
			// A new event wins over a clear in the same cycle.
			irq_st   <= (irq_st & ~ist_clr) | irq_set;
			irq_o    <= |(irq_st & irq_msk);
		end
	end

	// ------------------------------------------------------------------
	// Power state
	// ------------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			mhu_pkg::MHU_ASLEEP:
				if (wake_req)
					next_state = deep_flag ? mhu_pkg::MHU_WAKING :
						mhu_pkg::MHU_ACTIVE;
			mhu_pkg::MHU_WAKING:
				if (tick && wake_ms == 9'(mhu_pkg::DEEP_WAKE_MS - 1))
					next_state = mhu_pkg::MHU_ACTIVE; // see R18
			mhu_pkg::MHU_ACTIVE:
				if (pwr_cmd[mhu_pkg::PWR_SLEEP])
					next_state = mhu_pkg::MHU_ASLEEP;
			default:
				next_state = mhu_pkg::MHU_ASLEEP;
		endcase
	end

	// The indicator follows sleep alone; readiness is the clear line's job.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state     <= mhu_pkg::MHU_ACTIVE;
			deep_flag <= 1'b0;
			active_q  <= 1'b1;
			wake_ms   <= 9'h000;
			modem_awake_indicator_o <= 1'b1;
			modem_clear_line_n_o    <= 1'b1;
			ring_alert_n_o          <= 1'b1;
		end
		else
		begin
			state     <= next_state;
			active_q  <= active;
			deep_flag <= (active && pwr_cmd[mhu_pkg::PWR_SLEEP]) ?
				pwr_cmd[mhu_pkg::PWR_DEEP] : deep_flag;
			wake_ms   <= (state != mhu_pkg::MHU_WAKING) ? 9'h000 :
				(tick ? 9'(wake_ms + 1'b1) : wake_ms);
			modem_awake_indicator_o <= (next_state != mhu_pkg::MHU_ASLEEP); // see R7 R16
			modem_clear_line_n_o    <= !cts_rdy; // see R5 R17
			ring_alert_n_o          <= !ring_active; // see R1
		end
	end

	// ------------------------------------------------------------------
	// Serial receive, transmit and inactivity timer
	// ------------------------------------------------------------------
	// Receive samples mid-bit; a start bit gone high by then is a glitch.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rx_busy <= 1'b0;
			rx_cnt  <= 16'h0000;
			rx_bit  <= 4'h0;
			rx_shift <= 8'h00;
			rx_push <= 1'b0;
		end
		else
		begin
			rx_push <= rx_mid && (rx_bit == 4'h9) && rx_s;
			if (!rx_busy && !rx_s)
			begin
				rx_busy <= 1'b1;
				rx_cnt  <= baud_div >> 1;
				rx_bit  <= 4'h0;
			end
			else if (rx_mid)
			begin
				rx_cnt   <= baud_div - 16'h0001;
				rx_bit   <= rx_bit + 4'h1;
				rx_busy  <= !((rx_bit == 4'h0 && rx_s) || rx_bit == 4'h9);
				rx_shift <= (rx_bit != 4'h0 && rx_bit != 4'h9) ?
					{rx_s, rx_shift[7:1]} : rx_shift;
			end
			else if (rx_busy)
				rx_cnt <= rx_cnt - 16'h0001;
		end
	end

	// Transmit holds off while the host deasserts its request line.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			tx_busy     <= 1'b0;
			tx_cnt      <= 16'h0000;
			tx_bit      <= 4'h0;
			tx_shift    <= 10'h3FF;
			modem_txd_o <= 1'b1;
		end
		else if (tx_start)
		begin
			tx_busy  <= 1'b1; // see R14
			tx_cnt   <= baud_div - 16'h0001;
			tx_bit   <= 4'h0;
			tx_shift <= {1'b1, txq.rdata, 1'b0};
			modem_txd_o <= 1'b0;
		end
		else if (tx_busy && tx_cnt == 16'h0000)
		begin
			tx_cnt   <= baud_div - 16'h0001;
			tx_bit   <= tx_bit + 4'h1;
			tx_busy  <= (tx_bit != 4'h9);
			tx_shift <= {1'b1, tx_shift[9:1]};
			modem_txd_o <= (tx_bit == 4'h9) ? 1'b1 : tx_shift[1];
		end
		else if (tx_busy)
			tx_cnt <= tx_cnt - 16'h0001;
	end

	// The timer runs only while bytes wait, so an empty queue stays quiet.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			idle_ms    <= 16'h0000;
			idle_armed <= 1'b0;
		end
		else if (rx_push)
		begin
			idle_ms    <= 16'h0000;
			idle_armed <= 1'b1;
		end
		else if (to_hit || rxq.empty)
		begin
			idle_ms    <= 16'h0000; // see R12
			idle_armed <= 1'b0;
		end
		else if (tick && idle_armed)
			idle_ms <= idle_ms + 16'h0001;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence s_deep_wake;
		state == mhu_pkg::MHU_ASLEEP && wake_req && deep_flag;
	endsequence

	sequence s_wait_clear;
		(state == mhu_pkg::MHU_WAKING && modem_awake_indicator_o &&
			modem_clear_line_n_o) [*4];
	endsequence

	a_deep_wake_gap : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R18
		s_deep_wake |=> s_wait_clear)
		else $error("Clear line asserted too early after deep wake.");

	a_awake_tracks : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R16
		modem_awake_indicator_o == awake)
		else $error("Awake indicator disagrees with power state.");

	a_clear_asleep : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R17
		!modem_awake_indicator_o |-> modem_clear_line_n_o)
		else $error("Clear line low while asleep.");

	a_wake_request : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R4
		state == mhu_pkg::MHU_ASLEEP && !rts_s && ctrl[mhu_pkg::CTRL_WAKE_RTS]
		|=> state != mhu_pkg::MHU_ASLEEP)
		else $error("Request line did not wake the modem.");

	a_wake_pin : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R15
		state == mhu_pkg::MHU_ASLEEP && wk_s && ctrl[mhu_pkg::CTRL_DEDICATED_WAKE_PIN_ZERO]
		|=> ##1 modem_awake_indicator_o)
		else $error("Wake pin did not wake the modem.");

	a_ring_alert : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R1
		ring_go |=> ##1 !ring_alert_n_o)
		else $error("Ring output not driven after an event.");

	a_tx_flow_hold : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R14
		ctrl[mhu_pkg::CTRL_FLOW] && rts_s |-> !tx_start)
		else $error("Transmit started with host request deasserted.");

	a_bus_answer : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Bus answer not a single cycle after request.");
endmodule

`default_nettype wire

/* verif/mhu_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host end of the link; BIT is one serial bit in clock cycles.
module mhu_host_model #(
	parameter int BIT = 16
) (
	// Link pins
	input  wire logic clk_i,
	input  wire logic pause_i,
	input  wire logic txd_i,
	input  wire logic clear_n_i,
	output logic      rxd_o,
	output logic      req_n_o
);
	logic       obey = 1'b1;
	logic [7:0] got;
	int         got_n = 0;

	// Idle line high; request starts low so the modem stays reachable.
	initial
	begin
		rxd_o = 1'b1;
		req_n_o = 1'b0;
	end
	// Request low wakes the modem and lets it transmit.
	always @(posedge clk_i) req_n_o <= pause_i;
	// One 8N1 frame, LSB first, held back while clear is high.
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		while (obey && clear_n_i !== 1'b0) @(posedge clk_i);
		for (int i = 0; i < 10; i++)
		begin
			rxd_o <= f[i];
			repeat (BIT) @(posedge clk_i);
		end
	endtask
	// Mid-bit sampling tolerates a few cycles of skew on the start edge.
	always
	begin
		@(negedge txd_i);
		repeat (BIT / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge clk_i);
			got[i] = txd_i;
		end
		repeat (BIT) @(posedge clk_i);
		got_n++;
	end
endmodule

`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	typedef struct packed
	{
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
	} mhu_row_t;
	localparam int TK = 20;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic        wake = 1'b0;
	logic        pause = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] rd, q;
	logic        ack, rxd, txd, req_n, clr_n, awake, ring_n, irq;
	logic [3:0]  pins;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          ticks = 0;
	mhu_row_t    rs[7] = '{'{8'h04, 32'h0, 32'h1B}, '{8'h08, 32'h0, 32'h35},
		'{8'h0C, 32'h0, 32'h0}, '{8'h10, 32'h0, 32'h0},
		'{8'h14, 32'h0, 32'h06C8}, '{8'h18, 32'h0, 32'h0064_0064},
		'{8'h24, 32'h0, 32'h0}};
	mhu_row_t    rg[4] = '{'{8'h1B, 32'h1, 32'h1}, '{8'h1B, 32'h2, 32'h1},
		'{8'h03, 32'h1, 32'h0}, '{8'h23, 32'h1, 32'h1}};

	// Pins watched by the wait task.
	assign pins = {irq, ring_n, clr_n, awake};
	// Design with a short millisecond tick.
	mhu_uart_link #(.TICK_CYCLES(TK)) dut_u (.sys_clk_i(clk),
		.rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd),
		.wb_ack_o(ack), .host_rxd_i(rxd), .modem_txd_o(txd),
		.host_request_line_n_i(req_n), .modem_clear_line_n_o(clr_n),
		.dedicated_wake_pin_zero_i(wake), .modem_awake_indicator_o(awake),
		.ring_alert_n_o(ring_n), .irq_o(irq));
	mhu_host_model #(.BIT(16)) host_u (.clk_i(clk), .pause_i(pause),
		.txd_i(txd), .clear_n_i(clr_n), .rxd_o(rxd), .req_n_o(req_n));

	// Clock at 200 MHz.
	always #2.5 clk = ~clk;
	// Hang guard: the run needs about 21000 cycles.
	always @(posedge clk)
	begin
		ticks++;
		if (ticks == 60000)
		begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One classic cycle; the answer is taken at the edge that shows ack.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = rd;
		cyc <= 1'b0;
	endtask
	task automatic wt(input int k, input logic v, input int lim);
		int n;
		n = 0;
		while (pins[k] !== v && n < lim)
		begin
			n++;
			@(posedge clk);
		end
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		int n;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		// Reset values; the write to an unmapped place must vanish.
		wb(1'b1, 8'h24, 32'hFFFF_FFFF);
		foreach (rs[i])
		begin
			wb(1'b0, rs[i].a, 32'h0);
			chk(q, rs[i].e);
		end
		chk(32'(pins), 32'h5);
		$display("reset test done");
		// Ring sources, online mode and a two-tick ring length.
		wb(1'b1, 8'h18, 32'h0002_0064);
		wb(1'b1, 8'h14, 32'h10);
		foreach (rg[i])
		begin
			wb(1'b1, 8'h04, {24'h0, rg[i].a});
			wb(1'b1, 8'h1C, rg[i].d);
			wt(2, 1'b0, 8);
			n = 0;
			while (ring_n === 1'b0 && n < 99)
			begin
				n++;
				@(posedge clk);
			end
			chk(32'(n > 19 && n < 43), rg[i].e);
		end
		$display("ring test done");
		// A high request line holds the transmitter back.
		pause <= 1'b1;
		wb(1'b1, 8'h00, 32'hA5);
		repeat (200) @(posedge clk);
		chk(32'(host_u.got_n), 32'h0);
		pause <= 1'b0;
		repeat (220) @(posedge clk);
		chk({host_u.got_n[23:0], host_u.got}, 32'h01A5);
		// Receive interrupt, FIFO depth, overrun and inactivity timeout.
		wb(1'b1, 8'h10, 32'h9);
		host_u.send(8'h3C);
		wt(3, 1'b1, 40);
		chk(32'(irq), 32'h1);
		wb(1'b0, 8'h00, 32'h0);
		chk({24'h0, q[7:0]}, 32'h3C);
		wb(1'b1, 8'h0C, 32'hF);
		wt(3, 1'b0, 4);
		chk(32'(irq), 32'h0);
		for (int i = 0; i < 64; i++)
			host_u.send(8'(i));
		wt(1, 1'b1, 40);
		chk(32'(clr_n), 32'h1);
		host_u.obey = 1'b0;
		host_u.send(8'hEE);
		wb(1'b0, 8'h0C, 32'h0);
		chk(32'(q[3]), 32'h1);
		wb(1'b1, 8'h0C, 32'hF);
		repeat (1700) @(posedge clk);
		wb(1'b0, 8'h0C, 32'h0);
		chk(32'(q[1]), 32'h0);
		repeat (400) @(posedge clk);
		wb(1'b0, 8'h0C, 32'h0);
		chk(32'(q[1]), 32'h1);
		for (int i = 0; i < 64; i++)
		begin
			wb(1'b0, 8'h00, 32'h0);
			chk({24'h0, q[7:0]}, 32'(i));
		end
		wb(1'b1, 8'h10, 32'h0);
		wt(3, 1'b0, 4);
		chk(32'(irq), 32'h0);
		host_u.obey = 1'b1;
		$display("serial test done");
		// Light sleep, then deep sleep, each left by the request line.
		for (int k = 1; k < 4; k += 2)
		begin
			pause <= 1'b1;
			repeat (4) @(posedge clk);
			wb(1'b1, 8'h20, 32'(k));
			wt(0, 1'b0, 8);
			chk(32'(pins[1:0]), 32'h2);
			pause <= 1'b0;
			wt(0, 1'b1, 8);
			chk(32'(pins[1:0]), 32'(k));
		end
		repeat (344 * TK - 8) @(posedge clk);
		chk(32'(clr_n), 32'h1);
		wt(1, 1'b0, 2 * TK);
		chk(32'(clr_n), 32'h0);
		// The divider is written back to its 115200 value and read back.
		wb(1'b1, 8'h14, 32'h06C8);
		wb(1'b0, 8'h14, 32'h0);
		chk(q, 32'h06C8);
		// With flow and request wake off only the wake pin may wake the modem.
		wb(1'b1, 8'h04, 32'h4);
		wb(1'b1, 8'h20, 32'h1);
		repeat (10) @(posedge clk);
		chk(32'(awake), 32'h0);
		wake <= 1'b1;
		wt(0, 1'b1, 8);
		chk(32'(pins[1:0]), 32'h1);
		$display("power test done");
		wrap_up();
	end
endmodule

`default_nettype wire
